// File: logic/buck3_pkg.sv
// constants for the third buck converter control register
package buck3_pkg;

	// register map
	localparam logic [7:0] REG_ADDR      = 8'h18;
	localparam logic [7:0] REG_RESET     = 8'h98;
	localparam int         PFM_BIT       = 7;
	localparam int         RSVD_BIT      = 6;
	localparam int         CODE_MSB      = 5;
	localparam int         CODE_W        = 6;
	localparam logic [5:0] CODE_RESET    = 6'h18;
	localparam logic [5:0] ALT_CODE_DFLT = 6'h20;

	// voltage code map, millivolts
	localparam logic [5:0] FINE_LAST     = 6'h1A;
	localparam int         BASE_MV       = 900;
	localparam int         FINE_STEP_MV  = 25;
	localparam int         COARSE_MV     = 1550;
	localparam int         COARSE_STEP   = 50;
	localparam int         MV_W          = 12;

	// monitor blanking after a write
	localparam int         CLK_HZ        = 20_000_000;
	localparam int         BLANK_TIME_MS = 5;
	localparam int         BLANK_CYCLES  = BLANK_TIME_MS * (CLK_HZ / 1000);
	localparam int         BLANK_W       = 17;

endpackage

// File: logic/buck3_voltage_ctrl_reg.sv
// third buck converter control register with monitor blanking
`timescale 1ns/1ns

module buck3_voltage_ctrl_reg
	import buck3_pkg::*;
#(
	parameter int         BLANK_LEN = BLANK_CYCLES,
	parameter logic [5:0] ALT_CODE  = ALT_CODE_DFLT
)
(
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              rst_i,
	// register access port
	input  wire logic [7:0]        reg_addr_i,
	input  wire logic [7:0]        reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic              unlocked_i,
	output logic      [7:0]        reg_rdata_o,
	output logic                   reg_rvalid_o,
	output logic                   wr_refused_o,
	// power-up default strap
	input  wire logic              default_select_resistor_i,
	// converter control
	output logic                   pulse_skip_enable_o,
	output logic      [5:0]        voltage_code_o,
	output logic      [MV_W-1:0]   voltage_mv_o,
	// monitor gating
	input  wire logic              ov_detect_i,
	input  wire logic              uv_detect_i,
	output logic                   blanking_o,
	output logic                   ov_fault_o,
	output logic                   uv_fault_o
);

	// code to millivolts, fine steps then coarse steps
	function automatic logic [MV_W-1:0] code_to_mv(input logic [5:0] code);
		int mv;
		if (code <= FINE_LAST)
			mv = BASE_MV + FINE_STEP_MV * int'(code);
		else
			mv = COARSE_MV + COARSE_STEP * (int'(code) - int'(FINE_LAST));
		return MV_W'(mv);
	endfunction

	function automatic logic addr_hit(input logic [7:0] addr);
		return addr == REG_ADDR;
	endfunction

	logic                pfm_ff;
	logic                nxt_pfm;
	logic [5:0]          code_ff;
	logic [5:0]          nxt_code;
	logic                strap_pend_ff;
	logic                nxt_strap_pend;
	logic [BLANK_W-1:0]  blank_cnt_ff;
	logic [BLANK_W-1:0]  nxt_blank_cnt;
	logic                blank_ff;
	logic                nxt_blank;
	logic                ov_ff;
	logic                nxt_ov;
	logic                uv_ff;
	logic                nxt_uv;
	logic [7:0]          rdata_ff;
	logic [7:0]          nxt_rdata;
	logic                rvalid_ff;
	logic                nxt_rvalid;
	logic                refused_ff;
	logic                nxt_refused;
	logic [MV_W-1:0]     mv_ff;
	logic [MV_W-1:0]     nxt_mv;
	logic                wr_ok;
	logic                wr_locked;

	assign wr_ok     = reg_wr_i && addr_hit(reg_addr_i) && unlocked_i;
	assign wr_locked = reg_wr_i && addr_hit(reg_addr_i) && !unlocked_i;

	// register contents
	always_comb
	begin
		nxt_pfm        = pfm_ff;
		nxt_code       = code_ff;
		nxt_strap_pend = 1'b0;
		if (strap_pend_ff && default_select_resistor_i)
			nxt_code = ALT_CODE;
		if (wr_ok)
		begin
			nxt_pfm  = reg_wdata_i[PFM_BIT];
			nxt_code = reg_wdata_i[CODE_MSB:0];
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			pfm_ff        <= REG_RESET[PFM_BIT];
			code_ff       <= REG_RESET[CODE_MSB:0];
			strap_pend_ff <= 1'b1;
		end
		else
		begin
			pfm_ff        <= nxt_pfm;
			code_ff       <= nxt_code;
			strap_pend_ff <= nxt_strap_pend;
		end
	end

	// blanking of the voltage monitors after a write
	always_comb
	begin
		nxt_blank_cnt = blank_cnt_ff;
		if (wr_ok)
			nxt_blank_cnt = BLANK_W'(BLANK_LEN);
		else if (blank_cnt_ff != '0)
			nxt_blank_cnt = blank_cnt_ff - 1'b1;
		nxt_blank = nxt_blank_cnt != '0;
		nxt_ov    = ov_detect_i && !nxt_blank;
		nxt_uv    = uv_detect_i && !nxt_blank;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			blank_cnt_ff <= '0;
			blank_ff     <= 1'b0;
			ov_ff        <= 1'b0;
			uv_ff        <= 1'b0;
		end
		else
		begin
			blank_cnt_ff <= nxt_blank_cnt;
			blank_ff     <= nxt_blank;
			ov_ff        <= nxt_ov;
			uv_ff        <= nxt_uv;
		end
	end

	// read path and status
	always_comb
	begin
		nxt_rvalid  = reg_rd_i;
		nxt_rdata   = 8'h00;
		if (reg_rd_i && addr_hit(reg_addr_i))
		begin
			nxt_rdata[PFM_BIT]    = pfm_ff;
			nxt_rdata[RSVD_BIT]   = 1'b0;
			nxt_rdata[CODE_MSB:0] = code_ff;
		end
		nxt_refused = wr_locked;
		nxt_mv      = code_to_mv(nxt_code);
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			rdata_ff   <= 8'h00;
			rvalid_ff  <= 1'b0;
			refused_ff <= 1'b0;
			mv_ff      <= code_to_mv(CODE_RESET);
		end
		else
		begin
			rdata_ff   <= nxt_rdata;
			rvalid_ff  <= nxt_rvalid;
			refused_ff <= nxt_refused;
			mv_ff      <= nxt_mv;
		end
	end

	assign reg_rdata_o         = rdata_ff;
	assign reg_rvalid_o        = rvalid_ff;
	assign wr_refused_o        = refused_ff;
	assign pulse_skip_enable_o = pfm_ff;
	assign voltage_code_o      = code_ff;
	assign voltage_mv_o        = mv_ff;
	assign blanking_o          = blank_ff;
	assign ov_fault_o          = ov_ff;
	assign uv_fault_o          = uv_ff;

	// checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	// cycles since the last accepted write, saturating
	logic [BLANK_W:0] since_wr_ff;
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			since_wr_ff <= '1;
		else if (wr_ok)
			since_wr_ff <= '0;
		else if (since_wr_ff != '1)
			since_wr_ff <= since_wr_ff + 1'b1;
	end

	a_reset_value: assert property (
		$past(rst_i) |->
			pfm_ff == REG_RESET[PFM_BIT] && code_ff == REG_RESET[CODE_MSB:0])
		else $error("register not at reset value after reset");

	a_locked_write: assert property (
		wr_locked && !strap_pend_ff |=>
			$stable(pfm_ff) && $stable(code_ff) && wr_refused_o)
		else $error("locked write changed the register");

	a_blank_start: assert property (
		wr_ok && (ov_detect_i || uv_detect_i) |=>
			blanking_o && !ov_fault_o && !uv_fault_o)
		else $error("monitor not blanked after write");

	a_blank_length: assert property (
		$fell(blanking_o) |-> since_wr_ff == (BLANK_W+1)'(BLANK_LEN))
		else $error("blanking interval has wrong length");

	a_strap_default: assert property (
		strap_pend_ff && default_select_resistor_i && !wr_ok |=>
			voltage_code_o == ALT_CODE)
		else $error("strap default not loaded");

	a_pfm_write: assert property (
		wr_ok |=> pulse_skip_enable_o == $past(reg_wdata_i[PFM_BIT]))
		else $error("pulse skip bit not written");

	a_code_write: assert property (
		wr_ok |=> voltage_code_o == $past(reg_wdata_i[CODE_MSB:0])
			##0 voltage_mv_o == code_to_mv(voltage_code_o))
		else $error("voltage code or millivolts wrong");

	a_rsvd_zero: assert property (
		reg_rvalid_o |-> !reg_rdata_o[RSVD_BIT])
		else $error("reserved bit read as one");

	c_write_ok:   cover property (wr_ok ##1 blanking_o);
	c_write_lock: cover property (wr_locked ##1 wr_refused_o);
	c_blank_end:  cover property ($fell(blanking_o));
	c_read_back:  cover property (wr_ok ##2 reg_rd_i && addr_hit(reg_addr_i));

endmodule

// File: verif/buck3_voltage_ctrl_reg_tb_top.sv
// self-checking bench for the third buck converter control register
`timescale 1ns/1ns

module buck3_voltage_ctrl_reg_tb_top
	import buck3_pkg::*;
;
	localparam int         BLEN = 20;
	localparam logic [5:0] ALT  = 6'h20;

	typedef struct {
		logic [7:0]  wd;
		logic [7:0]  rb;
		logic [11:0] mv;
	} row_type;

	// write value, readback, millivolts
	row_type rows [6] = '{
		'{8'hE0, 8'hA0, 12'h73A}, '{8'h05, 8'h05, 12'h401},
		'{8'h1A, 8'h1A, 12'h60E}, '{8'h9B, 8'h9B, 12'h640},
		'{8'h3F, 8'h3F, 12'hD48}, '{8'hC0, 8'h80, 12'h384}};

	logic        clock_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic        unlocked_i = 1'b0;
	logic        default_select_resistor_i = 1'b0;
	logic        ov_detect_i = 1'b0;
	logic        uv_detect_i = 1'b0;
	logic [7:0]  reg_rdata_o;
	logic        reg_rvalid_o;
	logic        wr_refused_o;
	logic        pulse_skip_enable_o;
	logic [5:0]  voltage_code_o;
	logic [11:0] voltage_mv_o;
	logic        blanking_o;
	logic        ov_fault_o;
	logic        uv_fault_o;
	logic [7:0]  d;
	int          fails = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	buck3_voltage_ctrl_reg #(.BLANK_LEN(BLEN), .ALT_CODE(ALT))
	i_buck3_voltage_ctrl_reg (.clock_i(clock_i), .rst_i(rst_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .unlocked_i(unlocked_i),
		.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.wr_refused_o(wr_refused_o),
		.default_select_resistor_i(default_select_resistor_i),
		.pulse_skip_enable_o(pulse_skip_enable_o),
		.voltage_code_o(voltage_code_o), .voltage_mv_o(voltage_mv_o),
		.ov_detect_i(ov_detect_i), .uv_detect_i(uv_detect_i),
		.blanking_o(blanking_o), .ov_fault_o(ov_fault_o),
		.uv_fault_o(uv_fault_o));

	always #25 clock_i = ~clock_i;

	task test_done;
		$display("checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk_val(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task chk_flag(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task do_reset;
		@(posedge clock_i);
		rst_i <= 1'b1;
		repeat (8) @(posedge clock_i);
		rst_i <= 1'b0;
		@(negedge clock_i);
	endtask

	task wr(input logic [7:0] a, input logic [7:0] v, input logic u);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		unlocked_i <= u;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
		@(negedge clock_i);
	endtask

	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		@(negedge clock_i);
		chk_flag(reg_rvalid_o, 1'b1);
		v = reg_rdata_o;
	endtask

	// hang guard
	always @(posedge clock_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			fails++;
			test_done();
		end
	end

	initial
	begin
		do_reset();
		rd(8'h18, d);
		chk_val({4'h0, d}, 12'h098);
		chk_val(voltage_mv_o, 12'h5DC);
		chk_flag(pulse_skip_enable_o, 1'b1);
		rd(8'h17, d);
		chk_val({4'h0, d}, 12'h000);
		foreach (rows[i])
		begin
			wr(8'h18, rows[i].wd, 1'b1);
			chk_val({6'h00, voltage_code_o}, {6'h00, rows[i].rb[5:0]});
			chk_flag(pulse_skip_enable_o, rows[i].rb[7]);
			chk_val(voltage_mv_o, rows[i].mv);
			rd(8'h18, d);
			chk_val({4'h0, d}, {4'h0, rows[i].rb});
		end
		// locked write and foreign address leave the register alone
		wr(8'h18, 8'h11, 1'b0);
		chk_flag(wr_refused_o, 1'b1);
		chk_val({6'h00, voltage_code_o}, 12'h000);
		wr(8'h19, 8'h3F, 1'b1);
		chk_val({6'h00, voltage_code_o}, 12'h000);
		// second write mid-blank restarts the full interval
		@(posedge clock_i);
		ov_detect_i <= 1'b1;
		uv_detect_i <= 1'b1;
		wr(8'h18, 8'h05, 1'b1);
		repeat (9) @(negedge clock_i);
		wr(8'h18, 8'h05, 1'b1);
		for (int i = 0; i < BLEN; i++)
		begin
			chk_flag(blanking_o, 1'b1);
			chk_flag(ov_fault_o | uv_fault_o, 1'b0);
			@(negedge clock_i);
		end
		chk_flag(blanking_o, 1'b0);
		repeat (2) @(negedge clock_i);
		chk_flag(ov_fault_o & uv_fault_o, 1'b1);
		// strap high picks the alternate power-up code
		@(posedge clock_i);
		default_select_resistor_i <= 1'b1;
		do_reset();
		repeat (3) @(negedge clock_i);
		chk_val({6'h00, voltage_code_o}, {6'h00, ALT});
		chk_flag(pulse_skip_enable_o, 1'b1);
		chk_val(voltage_mv_o, 12'h73A);
		test_done();
	end
endmodule
